// ---- rtl/windowed_watchdog_counter.sv ----
// Windowed 16-bit watchdog counter with an AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "wdt_defines.svh"
`default_nettype none
module windowed_watchdog_counter
  import wdt_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_LSCLK_TICK,
  input wire logic I_HALT,
  input wire logic I_STOP,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_AWADDR,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  output logic [1:0] O_AXI_BRESP,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  input wire logic [31:0] I_AXI_ARADDR,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_WDT_RESET
);
  import wdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Period of the selected overflow time, minus one
  function automatic logic [15:0] ovf_limit(input logic [2:0] sel);
    ovf_limit = 16'((32'(`WDT_LIMIT_BASE) << sel) | 32'(`WDT_LIMIT_BASE));
  endfunction

  // First count at which a clear is accepted; select 3 leaves it always open
  function automatic logic [15:0] win_start(input logic [2:0] ots,
                                            input logic [1:0] wps);
    logic [15:0] lim;
    lim = ovf_limit(ots);
    win_start = (wps == `WDT_WIN_OPEN) ? 16'h0000 : 16'(lim >> (wps + 2'h1));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic tick_s1_q, tick_s2_q, tick_s3_q;
  logic aw_q, w_q;
  logic [`WDT_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wdt_cfg_t cfg_q;
  logic osc_stop_q, first_done_q, pend_q, rst_q;
  logic [15:0] cnt_q;
  logic tick, osc_run, run, wr_fire, wr_key, key_ok, clr_ok, bad, ovf;
  logic [15:0] limit;

  // The oscillator tick comes from another clock; the rising edge seen at s2 (s2 high, s3 low) feeds logic
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
    end
    else if (I_CE)
    begin
      tick_s1_q <= I_LSCLK_TICK;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end

  assign tick = tick_s2_q & ~tick_s3_q;
  assign limit = ovf_limit(cfg_q.overflow_time_sel);
  assign osc_run = !(!cfg_q.lowspeed_osc_option_bit && osc_stop_q);
  // Counting ignores flash activity entirely, so self-programming cannot
  // mask a hung loop
  assign run = osc_run && !(!cfg_q.lowspeed_osc_option_bit
                            && (I_HALT || I_STOP));

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data accepted in either order
  assign wr_fire = aw_q && w_q && !O_AXI_BVALID;
  assign wr_key = wr_fire && (awaddr_q == `WDT_OFS_KEY);
  assign key_ok = (wdata_q[`WDT_KEY_MSB:0] == `WDT_CLEAR_KEY) && wstrb_q[0]
                  && (wstrb_q[3:1] == 3'h0);
  assign clr_ok = wr_key && key_ok && !rst_q
                  && (!first_done_q
                      || cnt_q >= win_start(cfg_q.overflow_time_sel,
                                            cfg_q.window_period_sel));
  assign bad = wr_key && !clr_ok;
  assign ovf = tick && run && (cnt_q == limit) && !clr_ok;

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      O_AXI_AWREADY <= 1'b0;
      O_AXI_WREADY <= 1'b0;
      O_AXI_BVALID <= 1'b0;
      O_AXI_BRESP <= `WDT_RESP_OKAY;
    end
    else if (I_CE)
    begin
      O_AXI_AWREADY <= !aw_q && !(I_AXI_AWVALID && O_AXI_AWREADY);
      O_AXI_WREADY <= !w_q && !(I_AXI_WVALID && O_AXI_WREADY);
      if (I_AXI_AWVALID && O_AXI_AWREADY)
      begin
        aw_q <= 1'b1;
        awaddr_q <= I_AXI_AWADDR[`WDT_ADDR_W-1:0];
      end
      if (I_AXI_WVALID && O_AXI_WREADY)
      begin
        w_q <= 1'b1;
        wdata_q <= I_AXI_WDATA;
        wstrb_q <= I_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        O_AXI_BVALID <= 1'b1;
        O_AXI_BRESP <= (awaddr_q == `WDT_OFS_STAT) ? `WDT_RESP_SLVERR
                                                   : `WDT_RESP_OKAY;
      end
      else if (O_AXI_BVALID && I_AXI_BREADY)
      begin
        O_AXI_BVALID <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
    end
  end

  // Configuration and oscillator control registers
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      cfg_q <= `WDT_CFG_RESET;
      osc_stop_q <= 1'b0;
    end
    else if (I_CE && wr_fire)
    begin
      if (awaddr_q == `WDT_OFS_CFG && wstrb_q[0])
        cfg_q <= wdata_q[`WDT_OPT_BIT:`WDT_OTS_LSB];
      if (awaddr_q == `WDT_OFS_OSC && wstrb_q[0])
        osc_stop_q <= wdata_q[`WDT_OSC_STOP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter: a clear beats the overflow tick arriving in the same cycle
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      cnt_q <= 16'h0000;
    else if (I_CE)
    begin
      if (rst_q || clr_ok)
        cnt_q <= 16'h0000;
      else if (tick && run)
        cnt_q <= (cnt_q == limit) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end

  // A bad access while the oscillator is stopped waits for its next tick
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      first_done_q <= 1'b0;
      pend_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else if (I_CE)
    begin
      if (wr_key)
        first_done_q <= 1'b1;
      if (bad && !osc_run)
        pend_q <= 1'b1;
      else if (pend_q && osc_run && tick)
        pend_q <= 1'b0;
      if ((bad && osc_run) || (pend_q && osc_run && tick) || ovf)
        rst_q <= 1'b1;
    end
  end

  assign O_WDT_RESET = rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_AXI_ARREADY <= 1'b0;
      O_AXI_RVALID <= 1'b0;
      O_AXI_RDATA <= 32'h0000_0000;
      O_AXI_RRESP <= `WDT_RESP_OKAY;
    end
    else if (I_CE)
    begin
      O_AXI_ARREADY <= !O_AXI_RVALID && !(I_AXI_ARVALID && O_AXI_ARREADY);
      if (I_AXI_ARVALID && O_AXI_ARREADY)
      begin
        O_AXI_RVALID <= 1'b1;
        O_AXI_RRESP <= `WDT_RESP_OKAY;
        unique case (I_AXI_ARADDR[`WDT_ADDR_W-1:0])
          `WDT_OFS_KEY: O_AXI_RDATA <= {24'h000000, first_done_q ?
                                        `WDT_RD_USED : `WDT_RD_FRESH};
          `WDT_OFS_CFG: O_AXI_RDATA <= {26'h0000000, cfg_q};
          `WDT_OFS_OSC: O_AXI_RDATA <= 32'(osc_stop_q) << `WDT_OSC_STOP_BIT;
          `WDT_OFS_STAT: O_AXI_RDATA <= {15'h0000, rst_q, cnt_q};
          default:
          begin
            O_AXI_RDATA <= 32'h0000_0000;
            O_AXI_RRESP <= `WDT_RESP_SLVERR;
          end
        endcase
      end
      else if (O_AXI_RVALID && I_AXI_RREADY)
        O_AXI_RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_clear_at_top: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && clr_ok && tick && run && cnt_q == limit |=> cnt_q == 16'h0000
      && !O_WDT_RESET)
    else $error("clear at top count lost");

  chk_halt_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
    !cfg_q.lowspeed_osc_option_bit && (I_HALT || I_STOP) && !clr_ok && !rst_q
      |=> cnt_q == $past(cnt_q))
    else $error("counter moved in halt or stop");

  chk_resume_count: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && tick && run && !clr_ok && !rst_q
      && cnt_q != limit |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("resume did not continue from held count");

  chk_osc_stop_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
    !osc_run && !clr_ok && !rst_q |=> cnt_q == $past(cnt_q))
    else $error("counter moved with oscillator stopped");

  chk_bad_key_reset: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && wr_key && wdata_q[`WDT_KEY_MSB:0] != `WDT_CLEAR_KEY && osc_run
      |=> O_WDT_RESET)
    else $error("bad key did not reset");

  chk_partial_write: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && wr_key && wstrb_q != 4'h1 |=> O_WDT_RESET || pend_q)
    else $error("partial write ignored");

  chk_key_readback: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && I_AXI_ARVALID && O_AXI_ARREADY
      && I_AXI_ARADDR[`WDT_ADDR_W-1:0] == `WDT_OFS_KEY
      |=> O_AXI_RVALID && (O_AXI_RDATA[7:0] == `WDT_RD_FRESH
                           || O_AXI_RDATA[7:0] == `WDT_RD_USED))
    else $error("key register read wrong value");

  chk_first_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && wr_key && key_ok && !first_done_q && !rst_q
      |=> cnt_q == 16'h0000 && !O_WDT_RESET)
    else $error("first clear refused");

  chk_overflow_reset: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && ovf |=> O_WDT_RESET ##1 cnt_q == 16'h0000)
    else $error("overflow without reset");
endmodule // windowed_watchdog_counter
`default_nettype wire

// ---- shared/wdt_defines.svh ----
// Register map, key values and field positions of the watchdog block
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
`define WDT_ADDR_W 4
`define WDT_OFS_KEY 4'h0
`define WDT_OFS_CFG 4'h4
`define WDT_OFS_OSC 4'h8
`define WDT_OFS_STAT 4'hc
`define WDT_CLEAR_KEY 8'hac
`define WDT_KEY_MSB 7
`define WDT_WIN_OPEN 2'h3
`define WDT_RD_FRESH 8'h9a
`define WDT_RD_USED 8'h1a
`define WDT_OTS_LSB 0
`define WDT_WPS_LSB 3
`define WDT_OPT_BIT 5
`define WDT_OSC_STOP_BIT 1
`define WDT_RST_FLAG_BIT 16
`define WDT_LIMIT_BASE 16'h01ff
`define WDT_CFG_RESET 6'h3f
`define WDT_RESP_OKAY 2'b00
`define WDT_RESP_SLVERR 2'b10
`endif

// ---- shared/wdt_pkg.sv ----
// Types shared by the watchdog block
package wdt_pkg;
  typedef struct packed {
    logic lowspeed_osc_option_bit;
    logic [1:0] window_period_sel;
    logic [2:0] overflow_time_sel;
  } wdt_cfg_t;
endpackage

// ---- testbench/windowed_watchdog_counter_tb.sv ----
// Self-checking bench for the windowed watchdog counter
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_counter_tb;
  logic clk = 0, rst = 1, ce = 1, tk = 0, hlt = 0, stp = 0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0, rdata, rv_d;
  logic [3:0] ws = 0;
  logic [1:0] bresp, rresp, rsp;
  logic awr, wr_rdy, bv, arr, rv, wdr;
  int num_errors = 0, cmp_count = 0;
  int mcnt = 0, mrst = 0, opt = 1, ostop = 0, pend = 0;
  int wps = 3, lim = 65535, mfirst = 0;
  always #5 clk = ~clk;
  windowed_watchdog_counter uut (.I_CLK(clk), .I_RST(rst), .I_CE(ce),
    .I_LSCLK_TICK(tk), .I_HALT(hlt), .I_STOP(stp),
    .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_AWADDR(awa),
    .I_AXI_WVALID(wv), .O_AXI_WREADY(wr_rdy), .I_AXI_WDATA(wd),
    .I_AXI_WSTRB(ws), .O_AXI_BVALID(bv), .I_AXI_BREADY(br),
    .O_AXI_BRESP(bresp), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
    .I_AXI_ARADDR(ara), .O_AXI_RVALID(rv), .I_AXI_RREADY(rr),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_WDT_RESET(wdr));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang(input bit done);
    if (!done)
    begin
      num_errors++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    bit ad, dd;
    n = 0;
    ad = 0;
    dd = 0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= {28'h0, a};
    wv <= 1'b1;
    wd <= d;
    ws <= s;
    br <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (!ad && awr)
      begin
        ad = 1;
        awv <= 0;
      end
      if (!dd && wr_rdy)
      begin
        dd = 1;
        wv <= 0;
      end
    end while (!bv && n < 100);
    rsp = bresp;
    br <= 0;
    hang(bv);
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= {28'h0, a};
    rr <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arr)
        arv <= 0;
    end while (!rv && n < 100);
    rv_d = rdata;
    rsp = rresp;
    rr <= 0;
    hang(rv);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Model steps only once per tick, so ticks are spaced well past the sync
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      tk <= 1;
      if (pend && !(opt == 0 && ostop))
      begin
        mrst = 1;
        pend = 0;
      end
      else if (!mrst && !(opt == 0 && (hlt || stp || ostop)))
      begin
        if (mcnt == lim)
        begin
          mcnt = 0;
          mrst = 1;
        end
        else
          mcnt++;
      end
      repeat (2) @(posedge clk);
      tk <= 0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic stat;
    repeat (4) @(posedge clk);
    rd(4'hc);
    chk(rv_d, {15'h0, mrst[0], mcnt[15:0]});
    chk({31'h0, wdr}, {31'h0, mrst[0]});
  endtask
  // After the first key, a clear is legal only once the window has opened
  task automatic key(input logic [7:0] v, input logic [3:0] s);
    int win;
    win = (wps == 3) ? 0 : lim >> (wps + 1);
    wr(4'h0, {24'h0, v}, s);
    if (v == 8'hac && s == 4'h1 && !mrst && (!mfirst || mcnt >= win))
      mcnt = 0;
    else if (opt == 0 && ostop)
      pend = 1;
    else
    begin
      mrst = 1;
      mcnt = 0;
    end
    mfirst = 1;
  endtask
  // Never both selects zero, and the window leaves room before overflow
  task automatic cfg(input logic [7:0] v);
    wr(4'h4, {24'h0, v}, 4'h1);
    opt = v[5];
    wps = v[4:3];
    lim = (32'h1ff << v[2:0]) | 32'h1ff;
  endtask
  task automatic osc(input logic [7:0] v);
    wr(4'h8, {24'h0, v}, 4'h1);
    ostop = v[1];
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1;
    repeat (16) @(posedge clk);
    rst <= 0;
    mcnt = 0;
    mrst = 0;
    opt = 1;
    ostop = 0;
    pend = 0;
    wps = 3;
    lim = 65535;
    mfirst = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] bad;
    void'($urandom(32'h938d));
    do_reset();
    rd(4'h4);
    chk(rv_d, 32'h3f);
    rd(4'h0);
    chk(rv_d, 32'h9a);
    rd(4'h2);
    chk({30'h0, rsp}, 32'h2);
    wr(4'hc, 32'h0, 4'hf);
    chk({30'h0, rsp}, 32'h2);
    $display("test reset values done");
    cfg(8'h10);
    tick(3 + $urandom % 20);
    key(8'hac, 4'h1);
    stat();
    rd(4'h0);
    chk(rv_d, 32'h1a);
    $display("test first clear done");
    cfg(8'h18);
    tick(5 + $urandom % 9);
    stat();
    hlt <= 1'b1;
    tick(4);
    stat();
    hlt <= 1'b0;
    tick(3);
    stat();
    stp <= 1'b1;
    tick(4);
    stp <= 1'b0;
    tick(2);
    stat();
    osc(8'h02);
    tick(5);
    stat();
    osc(8'h00);
    tick(2);
    stat();
    cfg(8'h38);
    hlt <= 1'b1;
    tick(6);
    hlt <= 1'b0;
    stat();
    $display("test low power done");
    cfg(8'h18);
    key(8'hac, 4'h1);
    tick(511);
    stat();
    key(8'hac, 4'h1);
    stat();
    tick(511);
    // The key write lands on the same edge as the overflow tick
    fork
      tick(1);
      begin
        @(posedge clk);
        key(8'hac, 4'h1);
      end
    join
    // A clear in that cycle wins over the overflow
    mrst = 0;
    mcnt = 0;
    stat();
    tick(512);
    stat();
    do_reset();
    cfg(8'h19);
    key(8'hac, 4'h1);
    tick(1024);
    stat();
    $display("test overflow done");
    do_reset();
    bad = 8'($urandom);
    if (bad == 8'hac)
      bad = 8'h55;
    key(bad, 4'h1);
    stat();
    do_reset();
    key(8'hac, 4'h3);
    stat();
    do_reset();
    cfg(8'h18);
    osc(8'h02);
    key(8'h55, 4'h1);
    stat();
    osc(8'h00);
    tick(1);
    stat();
    $display("test illegal writes done");
    do_reset();
    cfg(8'h10);
    key(8'hac, 4'h1);
    tick(64);
    key(8'hac, 4'h1);
    stat();
    tick(3);
    key(8'hac, 4'h1);
    stat();
    $display("test window done");
    close_out();
  end
endmodule // windowed_watchdog_counter_tb
`default_nettype wire
